// ===== design/wcc_regbank.sv
// window comparator configuration bank: enables, thresholds, hysteresis
// assumes the serial front end gives one-cycle write strobes and
// samples read data combinationally on the addressed offset
// Notes on behaviour
// [RULE_01] bit 0 at 37h switches the whole comparator on or off, reset 0.
// [RULE_02] bits 7:1 at 37h always read as zero.
// [RULE_03] 34h holds channel alert enables, bit 1 ch1, bit 0 ch0, reset 0.
// [RULE_04] ch0 high limit is 12 bits: top nibble at 39h, low byte at 38h.
// [RULE_05] ch0 low limit is 12 bits: top nibble at 3bh, low byte at 3ah.
// [RULE_06] 6-bit hysteresis at 40h serves both ch0 comparators, 7:6 read 0.
// [RULE_07] ch1 high limit is 12 bits: top nibble at 3dh, low byte at 3ch.
// [RULE_08] ch1 low limit top nibble sits in bits 3:0 at 3fh.
// [RULE_09] bits 7:4 of every top-nibble register read as zero.
// [RULE_10] ch1 low limit low byte sits at 3eh and resets to zero.
// [RULE_11] 6-bit hysteresis at 41h serves both ch1 comparators.
// [RULE_12] a channel alerts only when global and channel enables are set.
// [RULE_13] reserved bits ignore writes; every register resets to zero.
`timescale 1ns/1ps
module wcc_regbank
	import wcc_pkg::*;
#(
	parameter int NUM_CH = 2
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_comparator_block_on,
	output logic [NUM_CH-1:0] o_chan_alert_active,
	output logic [WCC_THR_W-1:0] o_chan0_high_limit,
	output logic [WCC_THR_W-1:0] o_chan0_low_limit,
	output logic [WCC_HYS_W-1:0] o_chan0_hysteresis_value,
	output logic [WCC_THR_W-1:0] o_chan1_high_limit,
	output logic [WCC_THR_W-1:0] o_chan1_low_limit,
	output logic [WCC_HYS_W-1:0] o_chan1_hysteresis_value
);
	logic comparator_block_on_r;
	logic [NUM_CH-1:0] chan_alert_on_r;
	logic [7:0] rdata_nxt;
	logic we_chan_en;
	logic we_cmp_en;
	logic we_c0_hi_lo;
	logic we_c0_hi_top;
	logic we_c0_lo_lo;
	logic we_c0_lo_top;
	logic we_c0_hys;
	logic we_c1_hi_lo;
	logic we_c1_hi_top;
	logic we_c1_lo_lo;
	logic we_c1_lo_top;
	logic we_c1_hys;

	// strobes are nets so port connections follow address and strobe changes
	assign we_chan_en = i_wr_en && (i_addr == WCC_OFS_CHAN_EN);
	assign we_cmp_en = i_wr_en && (i_addr == WCC_OFS_CMP_EN);
	assign we_c0_hi_lo = i_wr_en && (i_addr == WCC_OFS_C0_HI_LO);
	assign we_c0_hi_top = i_wr_en && (i_addr == WCC_OFS_C0_HI_TOP);
	assign we_c0_lo_lo = i_wr_en && (i_addr == WCC_OFS_C0_LO_LO);
	assign we_c0_lo_top = i_wr_en && (i_addr == WCC_OFS_C0_LO_TOP);
	assign we_c0_hys = i_wr_en && (i_addr == WCC_OFS_C0_HYS);
	assign we_c1_hi_lo = i_wr_en && (i_addr == WCC_OFS_C1_HI_LO);
	assign we_c1_hi_top = i_wr_en && (i_addr == WCC_OFS_C1_HI_TOP);
	assign we_c1_lo_lo = i_wr_en && (i_addr == WCC_OFS_C1_LO_LO);
	assign we_c1_lo_top = i_wr_en && (i_addr == WCC_OFS_C1_LO_TOP);
	assign we_c1_hys = i_wr_en && (i_addr == WCC_OFS_C1_HYS);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n)
			comparator_block_on_r <= WCC_RESET_VAL[WCC_BLOCK_ON_BIT]; // see [RULE_13]
		else if (we_cmp_en)
			comparator_block_on_r <= i_wdata[WCC_BLOCK_ON_BIT]; // see [RULE_01]
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n)
			chan_alert_on_r <= WCC_RESET_VAL[NUM_CH-1:0]; // see [RULE_03]
		else if (we_chan_en)
			chan_alert_on_r <= i_wdata[NUM_CH-1:0]; // see [RULE_13]
	end

	wcc_chan_cfg u_ch0 (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_wdata(i_wdata),
		.i_we_hi_lo(we_c0_hi_lo),
		.i_we_hi_top(we_c0_hi_top),
		.i_we_lo_lo(we_c0_lo_lo),
		.i_we_lo_top(we_c0_lo_top),
		.i_we_hys(we_c0_hys),
		.o_high_limit(o_chan0_high_limit),
		.o_low_limit(o_chan0_low_limit),
		.o_hysteresis(o_chan0_hysteresis_value)
	);

	wcc_chan_cfg u_ch1 (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_wdata(i_wdata),
		.i_we_hi_lo(we_c1_hi_lo),
		.i_we_hi_top(we_c1_hi_top),
		.i_we_lo_lo(we_c1_lo_lo),
		.i_we_lo_top(we_c1_lo_top),
		.i_we_hys(we_c1_hys),
		.o_high_limit(o_chan1_high_limit),
		.o_low_limit(o_chan1_low_limit),
		.o_hysteresis(o_chan1_hysteresis_value)
	);

	// alert gating for the comparator core
	assign o_comparator_block_on = comparator_block_on_r;
	assign o_chan_alert_active = chan_alert_on_r &
		{NUM_CH{comparator_block_on_r}}; // see [RULE_12]

	// read mux; unmapped offsets return zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (i_addr)
			WCC_OFS_CMP_EN:
				rdata_nxt = {7'h00, comparator_block_on_r}; // see [RULE_02]
			WCC_OFS_CHAN_EN:
				rdata_nxt[NUM_CH-1:0] = chan_alert_on_r;
			WCC_OFS_C0_HI_LO: rdata_nxt = o_chan0_high_limit[7:0];
			WCC_OFS_C0_HI_TOP:
				rdata_nxt = {4'h0, o_chan0_high_limit[11:8]}; // see [RULE_09]
			WCC_OFS_C0_LO_LO: rdata_nxt = o_chan0_low_limit[7:0];
			WCC_OFS_C0_LO_TOP:
				rdata_nxt = {4'h0, o_chan0_low_limit[11:8]}; // see [RULE_09]
			WCC_OFS_C1_HI_LO: rdata_nxt = o_chan1_high_limit[7:0];
			WCC_OFS_C1_HI_TOP:
				rdata_nxt = {4'h0, o_chan1_high_limit[11:8]}; // see [RULE_09]
			WCC_OFS_C1_LO_LO: rdata_nxt = o_chan1_low_limit[7:0];
			WCC_OFS_C1_LO_TOP:
				rdata_nxt = {4'h0, o_chan1_low_limit[11:8]}; // see [RULE_08]
			WCC_OFS_C0_HYS:
				rdata_nxt = {2'h0, o_chan0_hysteresis_value}; // see [RULE_06]
			WCC_OFS_C1_HYS:
				rdata_nxt = {2'h0, o_chan1_hysteresis_value}; // see [RULE_11]
			default: rdata_nxt = 8'h00;
		endcase
	end
	assign o_rdata = rdata_nxt;

	// checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_cmp_en_write: assert property ( // see [RULE_01]
		we_cmp_en |=>
		o_comparator_block_on == $past(i_wdata[WCC_BLOCK_ON_BIT]))
		else $error("block enable did not follow write");
	a_cmp_en_resv: assert property ( // see [RULE_02]
		i_addr == WCC_OFS_CMP_EN |-> o_rdata[7:1] == 7'h00)
		else $error("reserved enable bits not zero");
	a_chan_en_hold: assert property ( // see [RULE_03]
		!we_chan_en |=> $stable(chan_alert_on_r))
		else $error("channel enable changed without write");
	a_chan_en_write: assert property ( // see [RULE_03]
		we_chan_en |=> chan_alert_on_r == $past(i_wdata[NUM_CH-1:0]))
		else $error("channel enable did not follow write");
	a_chan_en_resv: assert property ( // see [RULE_03]
		i_addr == WCC_OFS_CHAN_EN |-> o_rdata[7:NUM_CH] == '0)
		else $error("reserved channel enable bits not zero");

	a_c0_high_top: assert property ( // see [RULE_04]
		we_c0_hi_top |=> o_chan0_high_limit[11:8] == $past(i_wdata[3:0]))
		else $error("ch0 high top mismatch");
	a_c0_high_comp: assert property ( // see [RULE_04]
		we_c0_hi_top ##1 !we_c0_hi_top ##1 we_c0_hi_lo |=>
		o_chan0_high_limit == {$past(i_wdata[3:0], 3), $past(i_wdata)})
		else $error("ch0 high limit mismatch");
	a_c0_low_comp: assert property ( // see [RULE_05]
		we_c0_lo_lo |=> o_chan0_low_limit[7:0] == $past(i_wdata))
		else $error("ch0 low limit byte mismatch");
	a_c0_low_top: assert property ( // see [RULE_05]
		we_c0_lo_top |=> o_chan0_low_limit[11:8] == $past(i_wdata[3:0]))
		else $error("ch0 low limit top mismatch");
	a_c0_hys_wr: assert property ( // see [RULE_06]
		we_c0_hys |=> o_chan0_hysteresis_value == $past(i_wdata[5:0]))
		else $error("ch0 hysteresis mismatch");
	a_c0_hys_resv: assert property ( // see [RULE_06]
		i_addr == WCC_OFS_C0_HYS |-> o_rdata[7:6] == 2'h0)
		else $error("ch0 hysteresis reserved bits set");
	a_c1_high_top: assert property ( // see [RULE_07]
		we_c1_hi_top |=> o_chan1_high_limit[11:8] == $past(i_wdata[3:0]))
		else $error("ch1 high top mismatch");
	a_c1_high_byte: assert property ( // see [RULE_07]
		we_c1_hi_lo |=> o_chan1_high_limit[7:0] == $past(i_wdata))
		else $error("ch1 high byte mismatch");
	a_c1_low_nib: assert property ( // see [RULE_08]
		we_c1_lo_top |=> o_chan1_low_limit[11:8] == $past(i_wdata[3:0]))
		else $error("ch1 low top mismatch");
	a_c1_low_top: assert property ( // see [RULE_08]
		we_c1_lo_top ##1 i_addr == WCC_OFS_C1_LO_TOP |->
		o_rdata == {4'h0, $past(i_wdata[3:0])})
		else $error("ch1 low top readback wrong");
	a_top_resv: assert property ( // see [RULE_09]
		i_addr[7:4] == 4'h3 && i_addr[3] && i_addr[0] |->
		o_rdata[7:4] == 4'h0)
		else $error("top nibble register reserved bits set");
	a_c1_low_byte: assert property ( // see [RULE_10]
		we_c1_lo_lo |=> o_chan1_low_limit[7:0] == $past(i_wdata))
		else $error("ch1 low byte mismatch");
	a_c1_hys_wr: assert property ( // see [RULE_11]
		we_c1_hys ##1 i_addr == WCC_OFS_C1_HYS |->
		o_rdata == {2'h0, $past(i_wdata[5:0])})
		else $error("ch1 hysteresis readback wrong");

	a_alert_gate: assert property ( // see [RULE_12]
		!o_comparator_block_on |-> o_chan_alert_active == '0)
		else $error("alert active while comparator off");
	a_reset_clear: assert property ( // see [RULE_13]
		!$past(i_rst_n) |-> !o_comparator_block_on &&
		o_chan0_high_limit == '0 && o_chan1_hysteresis_value == '0)
		else $error("register not cleared by reset");

	c_block_on: cover property ($rose(o_comparator_block_on));
	c_both_alerts: cover property (o_chan_alert_active == '1);
	c_full_limit: cover property (o_chan1_low_limit == 12'hfff);
	c_limit_pair: cover property (we_c0_hi_top ##2 we_c0_hi_lo);
	c_resv_write: cover property (we_cmp_en && i_wdata[7:1] != 7'h00);
endmodule

// ===== design/wcc_pkg.sv
// package for the window comparator configuration bank
// assumes an 8-bit register port driven by the device's serial front end
package wcc_pkg;
	localparam logic [7:0] WCC_OFS_CHAN_EN = 8'h34;
	localparam logic [7:0] WCC_OFS_CMP_EN = 8'h37;
	localparam logic [7:0] WCC_OFS_C0_HI_LO = 8'h38;
	localparam logic [7:0] WCC_OFS_C0_HI_TOP = 8'h39;
	localparam logic [7:0] WCC_OFS_C0_LO_LO = 8'h3a;
	localparam logic [7:0] WCC_OFS_C0_LO_TOP = 8'h3b;
	localparam logic [7:0] WCC_OFS_C1_HI_LO = 8'h3c;
	localparam logic [7:0] WCC_OFS_C1_HI_TOP = 8'h3d;
	localparam logic [7:0] WCC_OFS_C1_LO_LO = 8'h3e;
	localparam logic [7:0] WCC_OFS_C1_LO_TOP = 8'h3f;
	localparam logic [7:0] WCC_OFS_C0_HYS = 8'h40;
	localparam logic [7:0] WCC_OFS_C1_HYS = 8'h41;
	localparam int WCC_BLOCK_ON_BIT = 0;
	localparam int WCC_CH0_ALERT_BIT = 0;
	localparam int WCC_CH1_ALERT_BIT = 1;
	localparam int WCC_TOP_W = 4;
	localparam int WCC_HYS_W = 6;
	localparam int WCC_THR_W = 12;
	localparam logic [7:0] WCC_RESET_VAL = 8'h00;
endpackage

// ===== design/wcc_chan_cfg.sv
// one channel's thresholds and hysteresis, byte-writable
// assumes the parent decodes the register offsets into write strobes
`timescale 1ns/1ps
module wcc_chan_cfg
	import wcc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_wdata,
	input wire logic i_we_hi_lo,
	input wire logic i_we_hi_top,
	input wire logic i_we_lo_lo,
	input wire logic i_we_lo_top,
	input wire logic i_we_hys,
	output logic [WCC_THR_W-1:0] o_high_limit,
	output logic [WCC_THR_W-1:0] o_low_limit,
	output logic [WCC_HYS_W-1:0] o_hysteresis
);
	logic [7:0] hi_bottom_r;
	logic [WCC_TOP_W-1:0] hi_top_r;
	logic [7:0] lo_bottom_r;
	logic [WCC_TOP_W-1:0] lo_top_r;
	logic [WCC_HYS_W-1:0] hys_r;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			hi_bottom_r <= WCC_RESET_VAL;
			lo_bottom_r <= WCC_RESET_VAL;
		end else begin
			if (i_we_hi_lo)
				hi_bottom_r <= i_wdata; // see [RULE_04] see [RULE_07]
			if (i_we_lo_lo)
				lo_bottom_r <= i_wdata; // see [RULE_05] see [RULE_10]
		end
	end

	// only the low nibble is stored; upper bits are dropped
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			hi_top_r <= WCC_RESET_VAL[WCC_TOP_W-1:0];
			lo_top_r <= WCC_RESET_VAL[WCC_TOP_W-1:0];
		end else begin
			if (i_we_hi_top)
				hi_top_r <= i_wdata[WCC_TOP_W-1:0]; // see [RULE_09]
			if (i_we_lo_top)
				lo_top_r <= i_wdata[WCC_TOP_W-1:0]; // see [RULE_08]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n)
			hys_r <= WCC_RESET_VAL[WCC_HYS_W-1:0];
		else if (i_we_hys)
			hys_r <= i_wdata[WCC_HYS_W-1:0]; // see [RULE_06] see [RULE_11]
	end

	assign o_high_limit = {hi_top_r, hi_bottom_r};
	assign o_low_limit = {lo_top_r, lo_bottom_r};
	assign o_hysteresis = hys_r;
endmodule

// ===== testbench/wcc_host_model.sv
// host-side model: issues register writes and reads on the parallel port
// assumes the bank takes a write at a rising edge with the strobe high
`timescale 1ns/1ps
module wcc_host_model (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr_en,
	output logic [7:0] o_wdata
);
	initial begin
		o_addr = 8'h00;
		o_wr_en = 1'b0;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_wr_en <= 1'b1;
		o_wdata <= d;
		@(posedge i_core_clk);
		o_wr_en <= 1'b0;
		o_wdata <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		@(posedge i_core_clk);
		#1 d = i_rdata;
	endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the comparator configuration bank
// assumes the host model drives the register port; no checker is bound
`timescale 1ns/1ps
module tb_top;
	import wcc_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] addr, wdata, rdata, rv;
	logic wr_en, blk;
	logic [1:0] act;
	logic [11:0] c0_hi, c0_lo, c1_hi, c1_lo;
	logic [5:0] c0_hys, c1_hys;
	logic [11:0] lim [4];
	logic [5:0] hys [2];
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #25 i_core_clk = ~i_core_clk;
	wcc_host_model host (.i_core_clk(i_core_clk), .i_rdata(rdata),
		.o_addr(addr), .o_wr_en(wr_en), .o_wdata(wdata));
	wcc_regbank #(.NUM_CH(2)) dut (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_addr(addr), .i_wr_en(wr_en),
		.i_wdata(wdata), .o_rdata(rdata), .o_comparator_block_on(blk),
		.o_chan_alert_active(act), .o_chan0_high_limit(c0_hi),
		.o_chan0_low_limit(c0_lo), .o_chan0_hysteresis_value(c0_hys),
		.o_chan1_high_limit(c1_hi), .o_chan1_low_limit(c1_lo),
		.o_chan1_hysteresis_value(c1_hys));
	always_comb begin
		lim[0] = c0_hi;
		lim[1] = c0_lo;
		lim[2] = c1_hi;
		lim[3] = c1_lo;
		hys[0] = c0_hys;
		hys[1] = c1_hys;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			stop_test();
		end
	end
	task automatic t_reset();
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		repeat (10) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		#1;
		chk({1'b0, blk, act, hys[0], hys[1]}, 16'h0000);
		for (int k = 0; k < 4; k++)
			chk(16'(lim[k]), 16'h0000);
		for (int a = 8'h34; a <= 8'h41; a++) begin
			host.rd(a[7:0], rv);
			chk(16'(rv), 16'h0000);
		end
	endtask
	task automatic t_global();
		host.wr(WCC_OFS_CMP_EN, 8'hff);
		host.rd(WCC_OFS_CMP_EN, rv);
		chk(16'(rv), 16'h0001);
		chk(16'(blk), 16'h0001);
		host.wr(WCC_OFS_CMP_EN, 8'hfe);
		host.rd(WCC_OFS_CMP_EN, rv);
		chk(16'(rv), 16'h0000);
		chk(16'(blk), 16'h0000);
	endtask
	task automatic t_alert();
		for (int g = 0; g < 2; g++) for (int e = 0; e < 4; e++) begin
			host.wr(WCC_OFS_CMP_EN, 8'(g));
			host.wr(WCC_OFS_CHAN_EN, 8'(e) | 8'hfc);
			host.rd(WCC_OFS_CHAN_EN, rv);
			chk(16'(rv), 16'(e));
			chk(16'(act), (g == 1) ? 16'(e) : 16'h0000);
		end
	endtask
	task automatic t_limits();
		for (int k = 0; k < 4; k++) begin
			host.wr(8'h39 + 8'(2 * k), 8'hf9 + 8'(k));
			chk(16'(lim[k]), 16'(9 + k) << 8);
			host.wr(8'h38 + 8'(2 * k), 8'h5a + 8'(k));
			host.rd(8'h39 + 8'(2 * k), rv);
			chk(16'(rv), 16'(9 + k));
			chk(16'(lim[k]), 16'h095a + 16'h0101 * 16'(k));
			host.rd(8'h38 + 8'(2 * k), rv);
			chk(16'(rv), 16'h005a + 16'(k));
		end
		chk(16'(c1_hi), 16'h0b5c);
		chk(16'(c1_lo), 16'h0c5d);
	endtask
	task automatic t_hys();
		host.wr(WCC_OFS_C0_HYS, 8'hff);
		host.wr(WCC_OFS_C1_HYS, 8'hd5);
		host.rd(WCC_OFS_C0_HYS, rv);
		chk({rv, 2'b00, hys[0]}, 16'h3f3f);
		host.rd(WCC_OFS_C1_HYS, rv);
		chk({rv, 2'b00, hys[1]}, 16'h1515);
		host.wr(8'h35, 8'hff);
		host.rd(8'h35, rv);
		chk(16'(rv), 16'h0000);
		host.rd(WCC_OFS_CHAN_EN, rv);
		chk({rv, 6'h00, act}, 16'h0303);
	endtask
	initial begin
		t_reset();
		t_global();
		t_alert();
		t_limits();
		t_hys();
		t_reset();
		stop_test();
	end
endmodule
